// ### rtl/output_format_scrambler.sv
// output format select, pin gating and data scrambler for the pixel output word
// assumes an apb master on clk_sys and a pixel clock pin sampled here
//
// The APB register port is this design's own decision.
module output_format_scrambler
   import outfmt_pkg::*;
#(
   parameter int W = outfmt_pkg::WORD_W
) (
   input  wire logic                          clk_sys,
   input  wire logic                          resetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [outfmt_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          pixel_clk,
   input  wire logic [W-1:0]                  data_in,
   input  wire logic                          sh2_timing,
   output logic [W-1:0]                       data_out,
   output logic                               data_oe,
   output logic                               cmos_select,
   output logic                               second_sensor_hold_pin
);
   import outfmt_pkg::*;

   if (W != WORD_W) begin : g_bad_width
      $error("output_format_scrambler: word width must be 21");
   end

   cfg_t           cfg;
   logic           first_pair_disable;
   logic [15:0]    word_count;
   logic           last_key;

   // pixel clock and word synchronisers
   logic           pclk_s1;
   logic           pclk_s2;
   logic           pclk_prev;
   logic [W-1:0]   din_s1;
   logic [W-1:0]   din_s2;
   logic           pix_rise;

   logic [W-1:0]   prs;
   logic [W-1:0]   pprs;
   logic [W-1:0]   next_word;
   logic           next_key;

   logic           setup_ph;
   logic           wr_acc;
   logic [ADDR_W-1:0] reg_idx;
   logic           idx_ok;
   logic           addr_ok;

   // apb decode
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite & ~pslverr;
   assign reg_idx  = {2'b00, paddr[ADDR_W-1:2]};

   function automatic logic idx_known(input logic [ADDR_W-1:0] idx);
      return (idx == IDX_CFG) || (idx == IDX_STATUS) || (idx == IDX_CTRL);
   endfunction

   assign idx_ok  = idx_known(reg_idx);
   assign addr_ok = idx_ok && (paddr[1:0] == 2'b00);

   // zero wait states: read data is staged in the setup cycle
   assign pready = psel & penable;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         // status is read-only, so writing it is an error as well
         pslverr <= !addr_ok || (pwrite && reg_idx == IDX_STATUS);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         case (reg_idx)
            IDX_CFG:    prdata <= {24'h00_0000, cfg[7:1], 1'b0};
            IDX_STATUS: prdata <= {15'h0000, last_key, word_count};
            IDX_CTRL:   prdata <= {31'h0000_0000, first_pair_disable};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // configuration register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cfg <= cfg_t'(CFG_RESET);
      end else if (wr_acc && reg_idx == IDX_CFG) begin
         cfg <= cfg_t'(pwdata[7:0] & CFG_WMASK);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         first_pair_disable <= CTRL_FPD_RESET;
      end else if (wr_acc && reg_idx == IDX_CTRL) begin
         first_pair_disable <= pwdata[CTRL_FPD_POS];
      end
   end

   // synchronisers: first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pclk_s1 <= 1'b0;
         pclk_s2 <= 1'b0;
         din_s1  <= '0;
         din_s2  <= '0;
      end else begin
         pclk_s1 <= pixel_clk;
         pclk_s2 <= pclk_s1;
         din_s1  <= data_in;
         din_s2  <= din_s1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pclk_prev <= 1'b0;
      end else begin
         pclk_prev <= pclk_s2;
      end
   end

   // one word per pixel clock rising edge
   assign pix_rise = pclk_s2 & ~pclk_prev;

   // generators step in lock-step with the words
   prs_gen #(
      .W    (WORD_W),
      .TAPS (PRS_TAPS),
      .SEED (PRS_SEED)
   ) u_prs (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .step    (pix_rise),
      .value   (prs)
   );

   prs_gen #(
      .W    (WORD_W),
      .TAPS (PRS_TAPS),
      .SEED (PPRS_SEED)
   ) u_pprs (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .step    (pix_rise),
      .value   (pprs)
   );

   function automatic logic [4:0] key_pos(input logic [1:0] sub, input logic fpd);
      logic [4:0] k;
      case (sub)
         2'b00:   k = KEY_SUB0;
         2'b01:   k = fpd ? KEY_SUB1_DIS : KEY_SUB1_EN;
         2'b10:   k = KEY_SUB2;
         2'b11:   k = KEY_SUB3;
         default: k = KEY_SUB0;
      endcase
      return k;
   endfunction

   // scrambled word for the current settings
   always_comb begin
      logic [4:0]   k;
      logic [W-1:0] kmask;
      k         = key_pos(cfg.submode, first_pair_disable);
      kmask     = W'(1) << k;
      next_key  = 1'b0;
      next_word = din_s2;
      case (cfg.mode)
         MODE_OFF: begin
            next_word = din_s2;
         end
         MODE_FULL: begin
            case (cfg.submode)
               2'b00:   next_word = din_s2 ^ prs;
               2'b01:   next_word = prs;
               2'b10:   next_word = din_s2 ^ pprs;
               2'b11:   next_word = pprs;
               default: next_word = din_s2;
            endcase
         end
         MODE_PRS0: begin
            // clear bit k then xor with prs bit zero
            next_key  = prs[0];
            next_word = (din_s2 & ~kmask) ^ {W{prs[0]}};
         end
         MODE_SELF: begin
            // key is data bit k, which goes out unchanged
            next_key  = din_s2[k];
            next_word = ((din_s2 ^ {W{din_s2[k]}}) & ~kmask) | (din_s2 & kmask);
         end
         default: begin
            next_word = din_s2;
         end
      endcase
   end

   // output word register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         data_out <= '0;
         last_key <= 1'b0;
      end else if (pix_rise) begin
         data_out <= cfg.out_en ? next_word : '0;
         last_key <= next_key;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         word_count <= 16'h0000;
      end else if (pix_rise && cfg.out_en) begin
         word_count <= word_count + 16'h0001;
      end
   end

   // pin enable follows the enable bit
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= cfg.out_en;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cmos_select <= 1'b0;
      end else begin
         cmos_select <= cfg.fmt_cmos;
      end
   end

   // hold pin carries data clock or timing waveform
   // data clock is the synced pixel clock registered once more, so it lags the pin by three cycles
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         second_sensor_hold_pin <= 1'b0;
      end else if (cfg.clk_ovr) begin
         second_sensor_hold_pin <= pclk_s2;
      end else begin
         second_sensor_hold_pin <= sh2_timing;
      end
   end

endmodule // output_format_scrambler

// ### inc/outfmt_pkg.sv
// package for the output format and scrambler block
// assumes a 32-bit apb register bus and a 21-bit output word
package outfmt_pkg;

   localparam int WORD_W = 21;
   localparam int ADDR_W = 8;

   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_CFG    = 8'h05;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h06;
   localparam logic [ADDR_W-1:0] IDX_CTRL   = 8'h07;

   // configuration field positions
   localparam int CFG_FMT_POS     = 7;
   localparam int CFG_OE_POS      = 6;
   localparam int CFG_CLKOVR_POS  = 5;
   localparam int CFG_MODE_LSB    = 3;
   localparam int CFG_SUBMODE_LSB = 1;
   localparam int CFG_RSVD_POS    = 0;
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] CFG_WMASK  = 8'hfe;
   localparam int CTRL_FPD_POS       = 0;
   localparam logic CTRL_FPD_RESET   = 1'b0;

   // key positions of the single-bit modes
   localparam logic [4:0] KEY_SUB0     = 5'h00;
   localparam logic [4:0] KEY_SUB1_EN  = 5'h05;
   localparam logic [4:0] KEY_SUB1_DIS = 5'h07;
   localparam logic [4:0] KEY_SUB2     = 5'h10;
   localparam logic [4:0] KEY_SUB3     = 5'h14;

   // pseudo-random generator shapes (x^21 + x^19 + 1 for both)
   localparam logic [WORD_W-1:0] PRS_TAPS  = 21'h140000;
   localparam logic [WORD_W-1:0] PRS_SEED  = 21'h000001;
   localparam logic [WORD_W-1:0] PPRS_SEED = 21'h1a5a5a;

   typedef enum logic [1:0] {
      MODE_OFF  = 2'b00,
      MODE_FULL = 2'b01,
      MODE_PRS0 = 2'b10,
      MODE_SELF = 2'b11
   } scr_mode_t;

   typedef struct packed {
      logic      fmt_cmos;
      logic      out_en;
      logic      clk_ovr;
      scr_mode_t mode;
      logic [1:0] submode;
      logic      rsvd;
   } cfg_t;

endpackage

// ### rtl/prs_gen.sv
// 21-bit pseudo-random sequence generator, one step per enable pulse
// assumes the receiver runs an identical generator with the same seed
module prs_gen #(
   parameter int                 W    = 21,
   parameter logic [W-1:0]       TAPS = '1,
   parameter logic [W-1:0]       SEED = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic         step,
   output logic [W-1:0]      value
);

   // refused at elaboration: an all-zero seed or tap set locks the register
   if (W < 2 || SEED == '0 || TAPS == '0) begin : g_bad_shape
      $error("prs_gen: width, seed and taps must be usable");
   end

   function automatic logic [W-1:0] lfsr_next(input logic [W-1:0] s);
      logic fb;
      fb = ^(s & TAPS);
      return {s[W-2:0], fb};
   endfunction

   // lock-step with the receiver: advance exactly once per word
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         value <= SEED;
      end else if (step) begin
         value <= lfsr_next(value);
      end
   end

endmodule // prs_gen

// ### dv/ofs_asserts.sv
// checker for the output format block, watching its ports only
// assumes apb writes reach the config word and the pixel clock pin is slow
module ofs_asserts
   import outfmt_pkg::*;
#(parameter int W = 21) (
   input wire logic              clk_sys,
   input wire logic              resetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire logic              pixel_clk,
   input wire logic              sh2_timing,
   input wire logic [W-1:0]      data_out,
   input wire logic              data_oe,
   input wire logic              cmos_select,
   input wire logic              second_sensor_hold_pin
);
   logic [7:0] sh;
   logic [3:0] age;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // shadow config; age lets registered copies settle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sh  <= 8'h00;
         age <= 4'h0;
      end else if (psel && penable && pwrite && paddr == 8'h14 && !pslverr) begin
         sh  <= pwdata[7:0] & CFG_WMASK;
         age <= 4'h0;
      end else if (age != 4'hf) begin
         age <= age + 4'h1;
      end
   end
   fmt_follow_a: assert property (age >= 4'h2 |-> cmos_select == sh[7])
      else $error("cmos select differs from config");
   oe_follow_a: assert property (age >= 4'h2 |-> data_oe == sh[6])
      else $error("output enable differs from config");
   off_zero_a: assert property (age == 4'hf && !sh[6] |-> data_out == '0)
      else $error("data driven while disabled");
   hold_normal_a: assert property (age >= 4'h3 && !sh[5]
      |=> second_sensor_hold_pin == $past(sh2_timing)) else $error("hold pin not timing wave");
   hold_clock_a: assert property ($rose(pixel_clk) && age == 4'hf && sh[5]
      |-> ##[1:5] second_sensor_hold_pin) else $error("hold pin missed data clock");
   word_pace_a: assert property (age == 4'hf && $changed(data_out)
      |-> $past(pixel_clk, 2)) else $error("word changed away from pixel clock");
   rsvd_read_a: assert property (psel && penable && !pwrite && paddr == 8'h14
      |-> prdata == {24'h0, sh}) else $error("config readback wrong");
   prs_shift_a: assert property (age == 4'hf && sh[6:3] == 4'b1001 && sh[1]
      && $changed(data_out) |-> data_out[W-1:1] == $past(data_out[W-2:0]))
      else $error("raw sequence not advancing");
endmodule // ofs_asserts
bind output_format_scrambler ofs_asserts #(.W(W)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pslverr(pslverr), .pixel_clk(pixel_clk), .sh2_timing(sh2_timing),
   .data_out(data_out), .data_oe(data_oe), .cmos_select(cmos_select),
   .second_sensor_hold_pin(second_sensor_hold_pin));

// ### dv/pixel_receiver.sv
// capture side model: takes each word at the pixel clock fall and descrambles
// assumes it is handed the config and pair disable that the sender uses
module pixel_receiver
   import outfmt_pkg::*;
(
   input wire logic                      clk_sys,
   input wire logic                      resetn,
   input wire logic                      pixel_clk,
   input wire outfmt_pkg::cfg_t          cfg,
   input wire logic                      fpd,
   input wire logic [outfmt_pkg::WORD_W-1:0] data_out,
   output logic [outfmt_pkg::WORD_W-1:0] rec
);
   logic [WORD_W-1:0] p, q, key;
   logic              last;
   int                k;
   function automatic logic [WORD_W-1:0] nx(logic [WORD_W-1:0] s);
      return {s[WORD_W-2:0], ^(s & PRS_TAPS)};
   endfunction
   always_comb begin
      k = cfg.submode == 2'b00 ? 0 : cfg.submode == 2'b01 ? (fpd ? 7 : 5) :
          cfg.submode == 2'b10 ? 16 : 20;
      key = cfg.mode == MODE_FULL ? (cfg.submode[1] ? q : p) :
            cfg.mode == MODE_OFF ? '0 : {WORD_W{data_out[k]}};
   end
   // same key, generators step once per word
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         p <= PRS_SEED;
         q <= PPRS_SEED;
         last <= 1'b0;
         rec <= '0;
      end else begin
         last <= pixel_clk;
         if (last && !pixel_clk) begin
            p <= nx(p);
            q <= nx(q);
            rec <= data_out ^ key;
            if (cfg.mode == MODE_SELF)
               rec[k] <= data_out[k];
         end
      end
   end
endmodule // pixel_receiver

// ### dv/test_output_format_scrambler.sv
// self-checking bench for the output format and scrambler block
// assumes the receiver model beside it and the checker bound to the block
module test_output_format_scrambler;
   timeunit 1ns;
   timeprecision 1ns;
   import outfmt_pkg::*;
   localparam logic [7:0] A_CFG = {IDX_CFG[5:0], 2'b00};
   localparam logic [7:0] A_CTRL = {IDX_CTRL[5:0], 2'b00};
   localparam logic [7:0] A_STAT = {IDX_STATUS[5:0], 2'b00};
   logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pixel_clk = 1'b0, sh2_timing = 1'b0, fpd = 1'b0, er, pready, pslverr;
   logic cmos_select, data_oe, hold_pin, sh_last, fb;
   logic lk = 1'b0;
   logic [15:0] nw = 16'h0000;
   logic [7:0] paddr = 8'h00, cf;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [WORD_W-1:0] data_in = '0, data_out, rec, p, q;
   cfg_t cfg = '0;
   int num_errors = 0;
   int num_checks = 0;
   output_format_scrambler DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pixel_clk(pixel_clk), .data_in(data_in),
      .sh2_timing(sh2_timing), .data_out(data_out), .data_oe(data_oe),
      .cmos_select(cmos_select), .second_sensor_hold_pin(hold_pin));
   pixel_receiver u_rx (.clk_sys(clk_sys), .resetn(resetn), .pixel_clk(pixel_clk),
      .cfg(cfg), .fpd(fpd), .data_out(data_out), .rec(rec));
   always #50 clk_sys = ~clk_sys;
   // sh_last keeps the value the block registered onto the hold pin
   always @(posedge clk_sys) begin
      sh_last <= sh2_timing;
      sh2_timing <= 1'($urandom);
   end
   function automatic logic [WORD_W-1:0] nx(logic [WORD_W-1:0] s);
      return {s[WORD_W-2:0], ^(s & PRS_TAPS)};
   endfunction
   function automatic int keypos(logic [1:0] s, logic f);
      return s == 2'b00 ? 0 : s == 2'b01 ? (f ? 7 : 5) : s == 2'b10 ? 16 : 20;
   endfunction
   function automatic logic [WORD_W-1:0] expect_out(logic [WORD_W-1:0] d, cfg_t c);
      logic [WORD_W-1:0] t;
      int k;
      k = keypos(c.submode, fpd);
      t = d;
      case (c.mode)
         MODE_FULL: t = (c.submode[0] ? '0 : d) ^ (c.submode[1] ? q : p);
         MODE_PRS0: begin
            t[k] = 1'b0;
            t = t ^ {WORD_W{p[0]}};
         end
         MODE_SELF: begin
            t = d ^ {WORD_W{d[k]}};
            t[k] = d[k];
         end
         default: ;
      endcase
      return c.out_en ? t : '0;
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      @(posedge clk_sys);
   endtask
   task automatic word(input logic [WORD_W-1:0] d);
      logic [WORD_W-1:0] x, rx;
      x = expect_out(d, cfg);
      rx = cfg.mode == MODE_PRS0 ? d & ~(21'h1 << keypos(cfg.submode, fpd)) : d;
      // key bit is latched on every word, counted words only while enabled
      lk = cfg.mode == MODE_PRS0 ? p[0] :
           cfg.mode == MODE_SELF ? d[keypos(cfg.submode, fpd)] : 1'b0;
      if (cfg.out_en)
         nw = nw + 16'h0001;
      data_in <= d;
      @(posedge clk_sys);
      pixel_clk <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk(32'(data_out), 32'(x));
      chk({31'h0, hold_pin}, {31'h0, cfg.clk_ovr ? 1'b1 : sh_last});
      pixel_clk <= 1'b0;
      p = nx(p);
      q = nx(q);
      repeat (2) @(posedge clk_sys);
      if (cfg.out_en && !(cfg.mode == MODE_FULL && cfg.submode[0]))
         chk(32'(rec), 32'(rx));
   endtask
   initial begin
      void'($urandom(32'h1b83));
      p = PRS_SEED;
      q = PPRS_SEED;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, A_CFG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      word(21'($urandom));
      for (int c = 0; c < 40; c++) begin
         cf = 8'($urandom);
         // drawn first so the register write and the receiver agree
         fb = c < 32 ? c[4] : 1'($urandom);
         fpd <= fb;
         if (c < 32)
            cf = {cf[7], 1'b1, cf[5], 4'(c), 1'b1};
         cfg <= cf;
         apb(1'b1, A_CTRL, {31'h0, fb});
         apb(1'b1, A_CFG, {24'h0, cf});
         apb(1'b0, A_CFG, 32'h0);
         chk(rd, {24'h0, cf & CFG_WMASK});
         chk({30'h0, cmos_select, data_oe}, {30'h0, cf[7:6]});
         word(21'h1fffff);
         word(21'($urandom));
         word(21'($urandom));
         apb(1'b0, A_STAT, 32'h0);
         chk(rd, {15'h0, lk, nw});
      end
      apb(1'b1, A_STAT, 32'h0);
      chk({31'h0, er}, 32'h1);
      tally_and_finish();
   end
endmodule // test_output_format_scrambler
